// file: include/psw_regs.vh
// Purpose: Register map, field positions, codes and timing constants of the
//          protection switch selector.
// Assumes: 32-bit AXI4-Lite register words, 40 MHz reference clock.
// Notes:   Definitions only.
`ifndef PSW_REGS_VH
`define PSW_REGS_VH

// ==========================================================================
// Register byte offsets
`define PSW_REG_CTRL 8'h00
`define PSW_REG_CMD 8'h04
`define PSW_REG_STATUS 8'h08
`define PSW_REG_PRIO 8'h0C
`define PSW_REG_CLIENT0 8'h10

// ==========================================================================
// Control register fields and reset value
`define PSW_CTRL_SPLIT 0
`define PSW_CTRL_OTN 1
`define PSW_CTRL_SDH 2
`define PSW_CTRL_TIM 3
`define PSW_CTRL_PL_LO 4
`define PSW_CTRL_PL_HI 5
`define PSW_CTRL_ROLE 6
`define PSW_CTRL_RST 7'h00

// Payload type codes.
`define PSW_PL_FRAMED 2'h0
`define PSW_PL_GE 2'h1
`define PSW_PL_TENGE 2'h2
`define PSW_PL_FC 2'h3

// Per-client register fields.
`define PSW_CL_YCAB 0
`define PSW_CL_ADMIN_DIS 1
`define PSW_CL_SQUELCH 2
`define PSW_CL_ALS 3
`define PSW_CL_RST 4'h0

// Status register fields above the per-client selection bits.
`define PSW_ST_SPLIT_REFUSED 8
`define PSW_ST_SPLIT_ACTIVE 9
`define PSW_ST_SOAK_W 10
`define PSW_ST_SOAK_P 11

// ==========================================================================
// Commands, written to CMD bits [2:0], client index in bits [7:4]
`define PSW_CMD_NONE 3'h0
`define PSW_CMD_CLEAR 3'h1
`define PSW_CMD_LOCKOUT 3'h2
`define PSW_CMD_FS_TO_P 3'h3
`define PSW_CMD_FS_TO_W 3'h4
`define PSW_CMD_MS_TO_P 3'h5
`define PSW_CMD_MS_TO_W 3'h6

// ==========================================================================
// Request priorities, larger wins
`define PSW_PRI_LO 4'h8
`define PSW_PRI_FS 4'h7
`define PSW_PRI_SF 4'h6
`define PSW_PRI_SD 4'h5
`define PSW_PRI_MS 4'h4
`define PSW_PRI_WTR 4'h3
`define PSW_PRI_DNR 4'h2
`define PSW_PRI_NR 4'h1

// ==========================================================================
// Trunk defect vector bit positions
`define PSW_D_OTU_LOS 0
`define PSW_D_OTU_LOF 1
`define PSW_D_OTU_LOM 2
`define PSW_D_OTU_AIS 3
`define PSW_D_ODU_AIS 4
`define PSW_D_OTU_BER_SF 5
`define PSW_D_OTU_BER_SD 6
`define PSW_D_SM_TIM 7
`define PSW_D_PM_TIM 8
`define PSW_D_SEC_LOF 9
`define PSW_D_SEC_LOS 10
`define PSW_D_LINE_SF 11
`define PSW_D_LINE_SD 12
`define PSW_D_LINE_AIS 13
`define PSW_D_SEC_TRACE 14
`define PSW_D_REGEN_TRACE 15
`define PSW_D_CARRIER 16
`define PSW_D_GE_OOS 17
`define PSW_D_TENGIG_SYNC 18
`define PSW_D_FC_SIGNAL 19
`define PSW_D_FC_OOS 20
`define PSW_D_FC_SYNC 21
`define PSW_NDEF 22

// ==========================================================================
// Timing
`define PSW_CLK_HZ 40000000
`define PSW_SOAK_MS 1000
`define PSW_HOLD_MS 1500

`endif

// file: verilog/psw_top.v
// Purpose: Protection switch selector for Y-cable and splitter groups.
// Assumes: Trunk defect inputs come from framers on REF_CLK.
// Operation
// - Y-cable: bridge transmit, select one receive path.
// - Switch: standby client laser off, active on.
// - Active laser off if disabled, squelched, shut.
// - Client receivers, trunk transmitters stay on unless disabled.
// - Independent selector per protected client facility.
// - Same facility pairs; one card role for all.
// - Splitter: enable chosen trunk receiver, route it.
// - Splitter: standby trunk transmitter stays enabled.
// - Refuse splitter while any client is Y-cable.
// - Priorities: lockout 8 down to no request 1.
// - Equal priority above do-not-revert: protect dominates.
// - Route traffic away from highest priority path.
// - Framing on: listed trunk defects give signal fail.
// - Framing on: degraded error rate gives degrade.
// - SONET trunk defects give fail or degrade.
// - SDH trunk defects give fail or degrade.
// - Trace mismatch with checking on gives fail.
// - Ethernet carrier, service, sync loss give fail.
// - Fibre Channel loss, service, sync give fail.
// - Hold selection 1.5 seconds after each switch.
// - Shared one-second soak-to-clear, restarts on recurrence.
// - Clear cancels lockout, forced and manual commands.
`timescale 1ns/1ps
`include "psw_regs.vh"

module psw_top #(
  parameter N_CLIENT = 4,
  parameter SOAK_CYC = `PSW_CLK_HZ / 1000 * `PSW_SOAK_MS,
  parameter HOLD_CYC = `PSW_CLK_HZ / 1000 * `PSW_HOLD_MS
) (
  input wire REF_CLK,
  input wire RSTN,
  input wire [`PSW_NDEF-1:0] W_DEFECT,
  input wire [`PSW_NDEF-1:0] P_DEFECT,
  output wire [N_CLIENT-1:0] CLIENT_TX_EN,
  output wire [N_CLIENT-1:0] CLIENT_RX_EN,
  output wire [N_CLIENT-1:0] RX_PATH_SEL,
  output wire [1:0] TRUNK_TX_EN,
  output wire [1:0] TRUNK_RX_EN,
  output wire TRUNK_RX_SEL,
  output wire CARD_ROLE_PROT,
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output wire [1:0] S_AXI_BRESP,
  output wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0] S_AXI_RRESP,
  output wire S_AXI_RVALID,
  input wire S_AXI_RREADY
);

  // ========================================================================
  // Condition to priority mapping

  // Signal-fail defects that share the one-second soak timer.
  function sf_soaked;
    input [`PSW_NDEF-1:0] d;
    input [6:0] c;
    begin
      if (c[`PSW_CTRL_OTN])
        sf_soaked = d[`PSW_D_OTU_LOS] | d[`PSW_D_OTU_LOF] | d[`PSW_D_OTU_LOM] |
                    d[`PSW_D_OTU_AIS] | d[`PSW_D_ODU_AIS] | d[`PSW_D_SM_TIM] |
                    d[`PSW_D_PM_TIM];
      else
        sf_soaked = ((c[`PSW_CTRL_PL_HI:`PSW_CTRL_PL_LO] == `PSW_PL_FRAMED) &
                     (d[`PSW_D_SEC_LOF] | d[`PSW_D_SEC_LOS] | d[`PSW_D_LINE_SF] |
                      d[`PSW_D_LINE_AIS])) |
                    (c[`PSW_CTRL_TIM] & (c[`PSW_CTRL_SDH] ? d[`PSW_D_REGEN_TRACE] :
                                         d[`PSW_D_SEC_TRACE])) |
                    ((c[`PSW_CTRL_PL_HI:`PSW_CTRL_PL_LO] == `PSW_PL_GE) &
                     (d[`PSW_D_CARRIER] | d[`PSW_D_GE_OOS])) |
                    ((c[`PSW_CTRL_PL_HI:`PSW_CTRL_PL_LO] == `PSW_PL_TENGE) &
                     d[`PSW_D_TENGIG_SYNC]) |
                    ((c[`PSW_CTRL_PL_HI:`PSW_CTRL_PL_LO] == `PSW_PL_FC) &
                     (d[`PSW_D_FC_SIGNAL] | d[`PSW_D_FC_OOS] | d[`PSW_D_FC_SYNC]));
    end
  endfunction

  function [3:0] max_pri;
    input [3:0] a;
    input [3:0] b;
    begin
      max_pri = (a > b) ? a : b;
    end
  endfunction

  // ========================================================================
  // Registers and shared state

  reg [6:0] ctrl_r;
  wire [4*N_CLIENT-1:0] client_r;
  wire [3*N_CLIENT-1:0] cmd_r;
  wire [N_CLIENT-1:0] sel_r;
  wire [8*N_CLIENT-1:0] pri_r;
  wire [3:0] path_pri [0:1];
  wire [1:0] soak_busy;
  wire [N_CLIENT-1:0] ycab;
  wire split_refused;
  wire split_ok;

  wire [2*`PSW_NDEF-1:0] defects = {P_DEFECT, W_DEFECT};

  genvar gi;

  // ========================================================================
  // Per-path soak-to-clear and path priority

  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_path
      wire [`PSW_NDEF-1:0] d = defects[gi*`PSW_NDEF +: `PSW_NDEF];
      wire sf_now = sf_soaked(d, ctrl_r);
      wire ber_sf = ctrl_r[`PSW_CTRL_OTN] & d[`PSW_D_OTU_BER_SF];
      wire sd_now = ctrl_r[`PSW_CTRL_OTN] ? d[`PSW_D_OTU_BER_SD] :
                    ((ctrl_r[`PSW_CTRL_PL_HI:`PSW_CTRL_PL_LO] == `PSW_PL_FRAMED) &
                     d[`PSW_D_LINE_SD]);
      reg [31:0] soak_r;
      reg [31:0] soak_nxt;

      // While the condition is present the timer stays loaded, so a
      // recurrence restarts the full interval once it clears again.
      always @*
      begin
        soak_nxt = soak_r;
        if (sf_now)
          soak_nxt = SOAK_CYC - 1;
        else if (soak_r != 32'h0000_0000)
          soak_nxt = soak_r - 32'h0000_0001;
      end

      always @(posedge REF_CLK or negedge RSTN)
      begin
        if (!RSTN)
          soak_r <= 32'h0000_0000;
        else
          soak_r <= soak_nxt;
      end

      assign soak_busy[gi] = (soak_r != 32'h0000_0000);
      assign path_pri[gi] = (sf_now | soak_busy[gi] | ber_sf) ? `PSW_PRI_SF :
                            sd_now ? `PSW_PRI_SD : `PSW_PRI_NR;
    end
  endgenerate

  // ========================================================================
  // Splitter mode

  assign split_refused = ctrl_r[`PSW_CTRL_SPLIT] & (|ycab);
  assign split_ok = ctrl_r[`PSW_CTRL_SPLIT] & ~(|ycab);

  // ========================================================================
  // AXI4-Lite slave

  reg aw_held_r;
  reg [7:0] awaddr_r;
  reg w_held_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg bvalid_r;
  reg [1:0] bresp_r;
  reg rvalid_r;
  reg [31:0] rdata_r;
  reg [1:0] rresp_r;

  wire aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
  wire w_take = S_AXI_WVALID & S_AXI_WREADY;
  wire wr_go = aw_held_r & w_held_r & ~bvalid_r;
  wire ar_take = S_AXI_ARVALID & S_AXI_ARREADY;
  wire wr_lane0 = wr_go & wstrb_r[0];
  wire wr_cmd = wr_lane0 & (awaddr_r == `PSW_REG_CMD);

  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a[1:0] == 2'h0) & (a < (`PSW_REG_CLIENT0 + 4 * N_CLIENT));
    end
  endfunction

  assign S_AXI_AWREADY = ~aw_held_r & ~bvalid_r;
  assign S_AXI_WREADY = ~w_held_r & ~bvalid_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = ~rvalid_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;

  always @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      aw_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      w_held_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      ctrl_r <= `PSW_CTRL_RST;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held_r <= 1'b1;
        awaddr_r <= S_AXI_AWADDR;
      end
      if (w_take)
      begin
        w_held_r <= 1'b1;
        wdata_r <= S_AXI_WDATA;
        wstrb_r <= S_AXI_WSTRB;
      end
      if (wr_go)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= addr_ok(awaddr_r) ? 2'h0 : 2'h2;
        if (wstrb_r[0] && awaddr_r == `PSW_REG_CTRL)
          ctrl_r <= wdata_r[6:0];
      end
      else if (bvalid_r && S_AXI_BREADY)
        bvalid_r <= 1'b0;
    end
  end

  // Read data.
  reg [31:0] rd_val;
  integer k;

  always @*
  begin
    rd_val = 32'h0000_0000;
    case (S_AXI_ARADDR)
      `PSW_REG_CTRL: rd_val = {25'h000_0000, ctrl_r};
      `PSW_REG_STATUS:
      begin
        rd_val[N_CLIENT-1:0] = sel_r;
        rd_val[`PSW_ST_SPLIT_REFUSED] = split_refused;
        rd_val[`PSW_ST_SPLIT_ACTIVE] = split_ok;
        rd_val[`PSW_ST_SOAK_W] = soak_busy[0];
        rd_val[`PSW_ST_SOAK_P] = soak_busy[1];
      end
      `PSW_REG_PRIO: rd_val[8*N_CLIENT-1:0] = pri_r;
      default:
      begin
        for (k = 0; k < N_CLIENT; k = k + 1)
          if (S_AXI_ARADDR == `PSW_REG_CLIENT0 + 4 * k)
            rd_val[6:0] = {cmd_r[3*k +: 3], client_r[4*k +: 4]};
      end
    endcase
  end

  always @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'h0;
    end
    else if (ar_take)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= addr_ok(S_AXI_ARADDR) ? 2'h0 : 2'h2;
    end
    else if (rvalid_r && S_AXI_RREADY)
      rvalid_r <= 1'b0;
  end

  // ========================================================================
  // Per-client selectors

  generate
    for (gi = 0; gi < N_CLIENT; gi = gi + 1)
    begin : g_client
      // Facility gi of this card pairs with facility gi of the peer card.
      wire [3:0] cfg = client_r[4*gi +: 4];
      wire [2:0] cmd = cmd_r[3*gi +: 3];
      wire active_en = cfg[`PSW_CL_YCAB] | ((gi == 0) & split_ok);
      wire [3:0] wp_r = pri_r[8*gi +: 4];
      wire [3:0] pp_r = pri_r[8*gi+4 +: 4];
      reg [3:0] cmd_w;
      reg [3:0] cmd_p;
      reg want;
      reg [31:0] hold_r;
      reg [3:0] cfg_r;
      reg [2:0] cmd_c_r;
      reg [7:0] pri_c_r;
      reg sel_c_r;
      wire on_card;
      assign client_r[4*gi +: 4] = cfg_r;
      assign cmd_r[3*gi +: 3] = cmd_c_r;
      assign pri_r[8*gi +: 8] = pri_c_r;
      assign sel_r[gi] = sel_c_r;

      always @*
      begin
        cmd_w = `PSW_PRI_NR;
        cmd_p = `PSW_PRI_NR;
        case (cmd)
          `PSW_CMD_LOCKOUT: cmd_p = `PSW_PRI_LO;
          `PSW_CMD_FS_TO_P: cmd_w = `PSW_PRI_FS;
          `PSW_CMD_FS_TO_W: cmd_p = `PSW_PRI_FS;
          `PSW_CMD_MS_TO_P: cmd_w = `PSW_PRI_MS;
          `PSW_CMD_MS_TO_W: cmd_p = `PSW_PRI_MS;
          default: cmd_w = `PSW_PRI_NR;
        endcase
      end

      // Traffic moves away from the higher request; a tie above
      // do-not-revert counts against protect, else the selection stays.
      always @*
      begin
        if (!active_en)
          want = 1'b0;
        else if (wp_r > pp_r)
          want = 1'b1;
        else if (pp_r > wp_r)
          want = 1'b0;
        else if (wp_r > `PSW_PRI_DNR)
          want = 1'b0;
        else
          want = sel_r[gi];
      end

      always @(posedge REF_CLK or negedge RSTN)
      begin
        if (!RSTN)
        begin
          cfg_r <= `PSW_CL_RST;
          cmd_c_r <= `PSW_CMD_NONE;
          pri_c_r <= {`PSW_PRI_NR, `PSW_PRI_NR};
          sel_c_r <= 1'b0;
          hold_r <= 32'h0000_0000;
        end
        else
        begin
          if (wr_lane0 && awaddr_r == `PSW_REG_CLIENT0 + 4 * gi)
            cfg_r <= wdata_r[3:0];
          if (wr_cmd && wdata_r[7:4] == gi)
          begin
            if (wdata_r[2:0] == `PSW_CMD_CLEAR)
              cmd_c_r <= `PSW_CMD_NONE;
            else if (wdata_r[2:0] <= `PSW_CMD_MS_TO_W)
              cmd_c_r <= wdata_r[2:0];
          end
          pri_c_r <= {max_pri(path_pri[1], cmd_p), max_pri(path_pri[0], cmd_w)};
          if (hold_r != 32'h0000_0000)
            hold_r <= hold_r - 32'h0000_0001;
          else if (want != sel_c_r)
          begin
            sel_c_r <= want;
            hold_r <= HOLD_CYC - 1;
          end
        end
      end

      // This card carries the active port when its role matches the path.
      assign on_card = ctrl_r[`PSW_CTRL_ROLE] ? sel_r[gi] : ~sel_r[gi];
      assign CLIENT_TX_EN[gi] = (~cfg[`PSW_CL_YCAB] | on_card) &
                                ~cfg[`PSW_CL_ADMIN_DIS] & ~cfg[`PSW_CL_SQUELCH] &
                                ~cfg[`PSW_CL_ALS];
      assign CLIENT_RX_EN[gi] = ~cfg[`PSW_CL_ADMIN_DIS];
      assign RX_PATH_SEL[gi] = sel_r[gi];
      assign ycab[gi] = cfg[`PSW_CL_YCAB];
    end
  endgenerate

  // ========================================================================
  // Trunk enables

  assign TRUNK_TX_EN = 2'b11;
  assign TRUNK_RX_SEL = split_ok & sel_r[0];
  assign TRUNK_RX_EN = split_ok ? {sel_r[0], ~sel_r[0]} : 2'b11;
  assign CARD_ROLE_PROT = ctrl_r[`PSW_CTRL_ROLE];

endmodule // psw_top

// file: sim/psw_checker.sv
// Purpose: Port checker for the protection switch selector.
// Assumes: One clock domain, bound to psw_top.
// Notes: The hold counter follows facility 0 only.
`timescale 1ns/1ps
module psw_checker #(
  parameter N_CLIENT = 4,
  parameter HOLD_CYC = 30
) (
  input wire REF_CLK,
  input wire RSTN,
  input wire [N_CLIENT-1:0] CLIENT_TX_EN,
  input wire [N_CLIENT-1:0] CLIENT_RX_EN,
  input wire [N_CLIENT-1:0] RX_PATH_SEL,
  input wire [1:0] TRUNK_TX_EN,
  input wire [1:0] TRUNK_RX_EN,
  input wire TRUNK_RX_SEL,
  input wire CARD_ROLE_PROT,
  input wire S_AXI_AWVALID,
  input wire S_AXI_AWREADY,
  input wire S_AXI_WVALID,
  input wire S_AXI_WREADY,
  input wire [1:0] S_AXI_BRESP,
  input wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire S_AXI_RVALID,
  input wire S_AXI_RREADY
);
  reg [31:0] since_r;
  reg sel_q_r;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  // ==========================================
  // Cycles since facility 0 last changed path, saturating at the hold time.
  always @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      since_r <= HOLD_CYC;
      sel_q_r <= 1'b0;
    end
    else
    begin
      since_r <= (RX_PATH_SEL[0] != sel_q_r) ? 32'h0000_0000 :
                 (since_r < HOLD_CYC) ? since_r + 32'h0000_0001 : since_r;
      sel_q_r <= RX_PATH_SEL[0];
    end
  end
  // ==========================================
  // Properties
  chk_hold_time: assert property ((RX_PATH_SEL[0] != sel_q_r) |-> since_r >= HOLD_CYC - 1)
    else $error("path changed inside hold time");
  chk_trunk_tx_on: assert property (TRUNK_TX_EN == 2'b11)
    else $error("trunk transmitter off");
  chk_split_rx: assert property ((TRUNK_RX_EN != 2'b11) |->
    TRUNK_RX_EN == {TRUNK_RX_SEL, !TRUNK_RX_SEL})
    else $error("trunk receiver not the routed one");
  chk_tx_gated: assert property (!CLIENT_RX_EN[0] |-> !CLIENT_TX_EN[0])
    else $error("laser on while port disabled");
  chk_standby_off: assert property ((TRUNK_RX_EN == 2'b11 && CLIENT_TX_EN[0]) |->
    RX_PATH_SEL[0] == CARD_ROLE_PROT)
    else $error("standby laser on");
  // Both halves are held first, so the response shows two edges after the take.
  chk_b_answer: assert property ((S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID &&
    S_AXI_WREADY) |-> ##2 S_AXI_BVALID)
    else $error("write response late");
  chk_b_stands: assert property ((S_AXI_BVALID && !S_AXI_BREADY) |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  chk_r_answer: assert property ((S_AXI_ARVALID && S_AXI_ARREADY) |=> S_AXI_RVALID)
    else $error("read data late");
  chk_r_stands: assert property ((S_AXI_RVALID && !S_AXI_RREADY) |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  chk_ar_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while data pending");
endmodule // psw_checker

bind psw_top psw_checker #(.N_CLIENT(N_CLIENT), .HOLD_CYC(HOLD_CYC)) u_chk (
  .REF_CLK(REF_CLK), .RSTN(RSTN), .CLIENT_TX_EN(CLIENT_TX_EN), .CLIENT_RX_EN(CLIENT_RX_EN),
  .RX_PATH_SEL(RX_PATH_SEL), .TRUNK_TX_EN(TRUNK_TX_EN), .TRUNK_RX_EN(TRUNK_RX_EN),
  .TRUNK_RX_SEL(TRUNK_RX_SEL), .CARD_ROLE_PROT(CARD_ROLE_PROT),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));

// file: sim/psw_stem_model.sv
// Purpose: Client equipment at the stem of the Y-cables.
// Assumes: Light is seen one cycle after a client laser turns on.
// Notes: Only this card's lasers are modelled.
`timescale 1ns/1ps
module psw_stem_model #(
  parameter N_CLIENT = 4
) (
  input wire clk,
  input wire [N_CLIENT-1:0] laser_on,
  output reg [N_CLIENT-1:0] light_seen
);
  always @(posedge clk)
  begin
    light_seen <= laser_on;
  end
endmodule // psw_stem_model

// file: sim/protection_switch_selector_tb_top.sv
// Purpose: Self-checking bench for the protection switch selector.
// Assumes: Short soak and hold counts; card role working except in the protect role laser check.
// Notes: Priorities and selection are modelled in the bench.
`timescale 1ns/1ps
`include "psw_regs.vh"
module protection_switch_selector_tb_top;
  localparam int SOAK = 20;
  localparam int HOLD = 30;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [21:0] w_def = 22'h00_0000;
  logic [21:0] p_def = 22'h00_0000;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  wire [3:0] ctx, crx, sel, seen;
  wire [1:0] ttx, trx, bresp, rresp;
  wire tsel, role, awready, wready, bvalid, arready, rvalid;
  wire [31:0] rdata;
  int n_mismatch = 0;
  int checks = 0;
  int cq[$] = '{4, 3, 2, 5, 6};
  int gq[$] = '{2, 4, 8};
  logic [31:0] rd, c;
  logic [21:0] d;
  logic [1:0] rs;
  logic [3:0] pw, pp;
  logic sel_m;
  always #12.5 clk = ~clk;
  psw_top #(.N_CLIENT(4), .SOAK_CYC(SOAK), .HOLD_CYC(HOLD)) uut (
    .REF_CLK(clk), .RSTN(rst_n), .W_DEFECT(w_def), .P_DEFECT(p_def), .CLIENT_TX_EN(ctx),
    .CLIENT_RX_EN(crx), .RX_PATH_SEL(sel), .TRUNK_TX_EN(ttx), .TRUNK_RX_EN(trx),
    .TRUNK_RX_SEL(tsel), .CARD_ROLE_PROT(role), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  psw_stem_model #(.N_CLIENT(4)) u_stem (.clk(clk), .laser_on(ctx), .light_seen(seen));
  // ==========================================
  // Checking and bus tasks
  task close_out;
    if (n_mismatch == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task lim(input int n);
    if (n > 40)
    begin
      n_mismatch++;
      $display("ERROR %0t handshake timeout", $time);
      close_out;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    int n;
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw || w)
    begin
      @(posedge clk);
      if (awready)
        aw = 1'b0;
      if (wready)
        w = 1'b0;
      awvalid <= aw;
      wvalid <= w;
      n++;
      lim(n);
    end
    while (!bvalid)
    begin
      @(posedge clk);
      n++;
      lim(n);
    end
    bready <= 1'b1;
    @(posedge clk);
    r = bresp;
    bready <= 1'b0;
  endtask
  task rdr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      lim(n);
    end while (!arready);
    arvalid <= 1'b0;
    while (!rvalid)
    begin
      @(posedge clk);
      n++;
      lim(n);
    end
    rready <= 1'b1;
    @(posedge clk);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Expected trunk priority for one path under the given control word.
  function automatic int pri(input logic [21:0] f, input logic [6:0] m);
    logic sf;
    logic sd;
    // Line-layer defects only count when the trunk carries a framed payload.
    sf = m[1] ? |(f & 22'h00_01BF) : ((m[5:4] == 2'h0) & |(f & 22'h00_2E00));
    sd = m[1] ? f[6] : ((m[5:4] == 2'h0) & f[12]);
    if (!m[1])
    begin
      sf = sf | (m[3] & (m[2] ? f[15] : f[14]));
      sf = sf | (m[5:4] == 2'h1 & (f[16] | f[17])) | (m[5:4] == 2'h2 & f[18]);
      sf = sf | (m[5:4] == 2'h3 & (|f[21:19]));
    end
    return sf ? 6 : (sd ? 5 : 1);
  endfunction
  // ==========================================
  // Main sequence
  initial
  begin
    void'($urandom(32'h6395_79f8));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(sel, 0, "reset path");
    rdr(`PSW_REG_PRIO, rd, rs);
    chk(rd, 32'h1111_1111, "reset priorities");
    rdr(`PSW_REG_CTRL, rd, rs);
    chk(rd, 0, "control reset");
    rdr(8'h40, rd, rs);
    chk(rs, 2'b10, "unmapped read");
    wr(8'h40, 32'h0000_0001, rs);
    chk(rs, 2'b10, "unmapped write");
    wr(`PSW_REG_CLIENT0, 32'h0000_0001, rs);
    repeat (16)
    begin
      c = $urandom & 32'h0000_003E;
      d = 22'h00_0001 << ($urandom % 22);
      wr(`PSW_REG_CTRL, c, rs);
      rdr(`PSW_REG_CTRL, rd, rs);
      chk(rd, c, "control readback");
      w_def <= d;
      repeat (4) @(posedge clk);
      rdr(`PSW_REG_PRIO, rd, rs);
      chk(rd[3:0], pri(d, c[6:0]), "defect priority");
      w_def <= 22'h00_0000;
      repeat (SOAK + 4) @(posedge clk);
    end
    wr(`PSW_REG_CTRL, 32'h0000_0002, rs);
    w_def <= 22'h00_0001;
    repeat (4) @(posedge clk);
    w_def <= 22'h00_0000;
    repeat (10) @(posedge clk);
    w_def <= 22'h00_0001;
    @(posedge clk);
    w_def <= 22'h00_0000;
    repeat (12) @(posedge clk);
    rdr(`PSW_REG_PRIO, rd, rs);
    chk(rd[3:0], 6, "soak restart");
    repeat (SOAK) @(posedge clk);
    rdr(`PSW_REG_PRIO, rd, rs);
    chk(rd[3:0], 1, "soak end");
    foreach (cq[i])
    begin
      pw = 4'h1;
      pp = 4'h1;
      case (cq[i])
        2: pp = 4'h8;
        3: pw = 4'h7;
        4: pp = 4'h7;
        5: pw = 4'h4;
        default: pp = 4'h4;
      endcase
      sel_m = pw > pp;
      wr(`PSW_REG_CMD, cq[i], rs);
      repeat (HOLD + 4) @(posedge clk);
      rdr(`PSW_REG_PRIO, rd, rs);
      chk(rd, {24'h11_1111, pp, pw}, "command priority");
      rdr(`PSW_REG_CLIENT0, rd, rs);
      chk(rd, {cq[i][2:0], 4'h1}, "command readback");
      c = {23'h00_0000, 3'b000, sel_m, 3'b111, ~sel_m, ~sel_m};
      chk({sel, ctx, seen[0]}, c, "path and lasers");
      wr(`PSW_REG_CMD, `PSW_CMD_CLEAR, rs);
      repeat (4) @(posedge clk);
      rdr(`PSW_REG_PRIO, rd, rs);
      chk(rd, 32'h1111_1111, "clear cancels");
    end
    w_def <= 22'h00_0001;
    repeat (HOLD + 4) @(posedge clk);
    chk(sel[0], 1, "away from fail");
    p_def <= 22'h00_0001;
    repeat (HOLD + 4) @(posedge clk);
    chk(sel[0], 0, "equal fail picks working");
    w_def <= 22'h00_0000;
    p_def <= 22'h00_0000;
    repeat (SOAK + 4) @(posedge clk);
    foreach (gq[i])
    begin
      wr(`PSW_REG_CLIENT0, 32'h0000_0001 | gq[i], rs);
      @(posedge clk);
      chk({ctx[0], crx[0]}, {1'b0, gq[i] != 2}, "laser gating");
    end
    wr(`PSW_REG_CLIENT0, 32'h0000_0001, rs);
    @(posedge clk);
    chk({ctx[0], crx[0], ttx}, 4'b1111, "lasers restored");
    wr(`PSW_REG_CTRL, 32'h0000_0042, rs);
    @(posedge clk);
    chk({role, ctx[0]}, 2'b10, "protect role laser");
    wr(`PSW_REG_CTRL, 32'h0000_0003, rs);
    rdr(`PSW_REG_STATUS, rd, rs);
    chk({rd[9:8], trx}, 4'b0111, "splitter refused");
    wr(`PSW_REG_CLIENT0, 32'h0000_0000, rs);
    rdr(`PSW_REG_STATUS, rd, rs);
    chk({rd[9:8], trx, tsel}, 5'b10010, "splitter on working");
    w_def <= 22'h00_0001;
    repeat (HOLD + 4) @(posedge clk);
    chk({trx, tsel, ttx}, 5'b10111, "splitter on protect");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({sel, trx, ctx[0]}, 7'b0000111, "mid-run reset");
    close_out;
  end
endmodule // protection_switch_selector_tb_top
